/* File: core/fcc_core.sv */
// Fan duty-cycle controller: register file, mode logic and duty register.
// Assumes an internal register port from the serial interface engine and
// temperature and speed-count inputs produced on the same clock.
`timescale 1ns/1ps

module fcc_core #(
	parameter int TICK_CYCLES = fcc_pkg::BASE_TICK_CYCLES
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [7:0] remote_temp_in,
	input wire logic [7:0] local_temp_in,
	input wire logic [15:0] speed_count_in,
	output logic [7:0] duty_out
);

	// ==========================================================
	// Helper functions

	// Duty demand of one temperature loop.
	function automatic logic [7:0] loop_duty(input logic [7:0] temp, input logic [7:0] ctrl,
			input logic [7:0] min_duty, input logic [7:0] psv);
		logic [7:0] low;
		logic [7:0] slope;
		logic [7:0] excess;
		logic [7:0] reach;
		logic [10:0] prod;
		logic [11:0] sum;
		low = {3'h0, ctrl[fcc_pkg::LOW_TEMP_HI_BIT:fcc_pkg::LOW_TEMP_LO_BIT]};
		slope = {5'h0, ctrl[fcc_pkg::SLOPE_HI_BIT:fcc_pkg::SLOPE_LO_BIT]};
		excess = temp - low;
		reach = 8'h00;
		prod = {3'h0, excess} * {3'h0, slope};
		sum = {4'h0, min_duty} + {1'h0, prod};
		if (slope != 8'h00) begin
			reach = (fcc_pkg::DUTY_FULL - min_duty) / slope;
		end
		if (temp <= psv) begin
			loop_duty = 8'h00;
		end else if (temp <= low) begin
			loop_duty = min_duty;
		end else if (slope != 8'h00 && excess >= reach) begin
			loop_duty = fcc_pkg::DUTY_FULL;
		end else if (sum > {4'h0, fcc_pkg::DUTY_FULL}) begin
			loop_duty = fcc_pkg::DUTY_FULL;
		end else begin
			loop_duty = sum[7:0];
		end
	endfunction : loop_duty

	// Moves a duty value toward a goal by at most one step, saturating.
	function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] goal,
			input logic [7:0] step);
		if (goal > cur) begin
			step_toward = (goal - cur > step) ? cur + step : goal;
		end else begin
			step_toward = (cur - goal > step) ? cur - step : goal;
		end
	endfunction : step_toward

	// Ramp threshold in duty counts for a threshold code.
	function automatic logic [7:0] threshold_of(input logic [1:0] code);
		case (code)
			2'h0: threshold_of = 8'h00;
			2'h1: threshold_of = 8'h02;
			2'h2: threshold_of = 8'h04;
			default: threshold_of = 8'h08;
		endcase
	endfunction : threshold_of

	// ==========================================================
	// State and decode
	fcc_pkg::fcc_state_type st_reg;
	fcc_pkg::fcc_state_type st_next;
	fcc_pkg::fcc_mode_type mode;
	logic meas_en;
	logic meas_mode;
	logic force_low;
	logic gradual;
	logic [7:0] step;
	logic [7:0] thresh;
	logic [2:0] interval;
	logic [6:0] sub_inc;
	logic [6:0] rate_mask;
	logic base_tick;
	logic rate_tick;
	logic speed_tick;
	logic [7:0] open_duty;
	logic [7:0] remote_demand;
	logic [7:0] local_demand;
	logic [7:0] raw_target;
	logic [7:0] temp_target;
	logic [7:0] ramp_diff;
	logic [16:0] meas_wide;
	logic [16:0] tgt_wide;
	logic [7:0] speed_duty;
	logic [7:0] rdata_mux;

	// Field decode of the configuration registers.
	assign mode = fcc_pkg::fcc_mode_type'(st_reg.config_one[fcc_pkg::MODE_HI_BIT:fcc_pkg::MODE_LO_BIT]);
	assign meas_en = st_reg.config_two[fcc_pkg::SPEED_MEAS_EN_BIT];
	assign meas_mode = st_reg.config_two[fcc_pkg::SPEED_MEAS_MODE_BIT];
	assign force_low = meas_en && !meas_mode;
	assign gradual = st_reg.duty_ramp_control[fcc_pkg::GRADUAL_BIT];
	assign step = {6'h00, st_reg.duty_ramp_control[fcc_pkg::STEP_HI_BIT:fcc_pkg::STEP_LO_BIT]} + 8'h01;
	assign thresh = threshold_of(
		st_reg.duty_ramp_control[fcc_pkg::THRESH_HI_BIT:fcc_pkg::THRESH_LO_BIT]);
	assign interval = st_reg.duty_ramp_control[fcc_pkg::INTERVAL_HI_BIT:fcc_pkg::INTERVAL_LO_BIT];

	// Timebase: a 62.5 ms base tick and a count of base ticks above it.
	assign base_tick = (st_reg.tick_cnt == 22'(TICK_CYCLES - 1));
	assign sub_inc = st_reg.sub_cnt + 7'h01;
	assign rate_mask = 7'((8'h01 << interval) - 8'h01);
	assign rate_tick = base_tick && ((sub_inc & rate_mask) == 7'h00);
	assign speed_tick = base_tick && ((sub_inc & (st_reg.misc_config_four[fcc_pkg::FAST_SAMPLE_BIT]
		? fcc_pkg::FAST_SAMPLE_MASK : fcc_pkg::SLOW_SAMPLE_MASK)) == 7'h00);

	// Open-loop duty with the low-duty cutoff.
	assign open_duty = (force_low && st_reg.duty_setting < fcc_pkg::DUTY_SEVEN_PCT)
		? 8'h00 : st_reg.duty_setting;

	// Temperature loop demands and the chosen target.
	assign remote_demand = loop_duty(remote_temp_in, st_reg.remote_loop, st_reg.min_temp_duty,
		st_reg.passive_cool_temp);
	assign local_demand = loop_duty(local_temp_in, st_reg.local_loop, st_reg.min_temp_duty,
		st_reg.passive_cool_temp);
	assign raw_target = (mode == fcc_pkg::MODE_MAX_LOOP && local_demand > remote_demand)
		? local_demand : remote_demand;
	assign temp_target = (force_low && raw_target < fcc_pkg::DUTY_SEVEN_PCT)
		? 8'h00 : raw_target;
	assign ramp_diff = (temp_target > st_reg.duty)
		? temp_target - st_reg.duty : st_reg.duty - temp_target;

	// Speed regulator: a larger count means a slower fan.
	assign meas_wide = {1'h0, speed_count_in};
	assign tgt_wide = {1'h0, st_reg.speed_target};
	always_comb begin
		speed_duty = st_reg.duty;
		if (meas_wide > tgt_wide + fcc_pkg::SPEED_BAND) begin
			speed_duty = step_toward(st_reg.duty, fcc_pkg::DUTY_FULL, step);
		end else if (meas_wide + fcc_pkg::SPEED_BAND < tgt_wide) begin
			speed_duty = step_toward(st_reg.duty, 8'h00, step);
		end
		if (!meas_mode && speed_duty < fcc_pkg::DUTY_THIRTY_PCT) begin
			speed_duty = fcc_pkg::DUTY_THIRTY_PCT;
		end
	end

	// Register read multiplexer; unmapped offsets read zero.
	always_comb begin
		case (reg_addr_in)
			fcc_pkg::ADDR_CONFIG_ONE: rdata_mux = st_reg.config_one;
			fcc_pkg::ADDR_CONFIG_TWO: rdata_mux = st_reg.config_two;
			fcc_pkg::ADDR_MISC_CONFIG_FOUR: rdata_mux = st_reg.misc_config_four;
			fcc_pkg::ADDR_DUTY_RAMP_CONTROL: rdata_mux = st_reg.duty_ramp_control;
			fcc_pkg::ADDR_DUTY_SETTING: rdata_mux = st_reg.duty_setting;
			fcc_pkg::ADDR_REMOTE_LOOP: rdata_mux = st_reg.remote_loop;
			fcc_pkg::ADDR_LOCAL_LOOP: rdata_mux = st_reg.local_loop;
			fcc_pkg::ADDR_MIN_TEMP_DUTY: rdata_mux = st_reg.min_temp_duty;
			fcc_pkg::ADDR_PASSIVE_COOL: rdata_mux = st_reg.passive_cool_temp;
			fcc_pkg::ADDR_SPEED_TARGET_LO: rdata_mux = st_reg.speed_target[7:0];
			fcc_pkg::ADDR_SPEED_TARGET_HI: rdata_mux = st_reg.speed_target[15:8];
			default: rdata_mux = 8'h00;
		endcase
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		if (reg_rd_in) begin
			st_next.rdata = rdata_mux;
		end
		if (reg_wr_in) begin
			case (reg_addr_in)
				fcc_pkg::ADDR_CONFIG_ONE: st_next.config_one = reg_wdata_in;
				fcc_pkg::ADDR_CONFIG_TWO: st_next.config_two = reg_wdata_in;
				fcc_pkg::ADDR_MISC_CONFIG_FOUR: st_next.misc_config_four = reg_wdata_in;
				fcc_pkg::ADDR_DUTY_RAMP_CONTROL: st_next.duty_ramp_control = reg_wdata_in;
				fcc_pkg::ADDR_DUTY_SETTING: st_next.duty_setting = reg_wdata_in;
				fcc_pkg::ADDR_REMOTE_LOOP: st_next.remote_loop = reg_wdata_in;
				fcc_pkg::ADDR_LOCAL_LOOP: st_next.local_loop = reg_wdata_in;
				fcc_pkg::ADDR_MIN_TEMP_DUTY: st_next.min_temp_duty = reg_wdata_in;
				fcc_pkg::ADDR_PASSIVE_COOL: st_next.passive_cool_temp = reg_wdata_in;
				fcc_pkg::ADDR_SPEED_TARGET_LO: st_next.speed_target[7:0] = reg_wdata_in;
				fcc_pkg::ADDR_SPEED_TARGET_HI: st_next.speed_target[15:8] = reg_wdata_in;
				default: st_next.rdata = st_next.rdata;
			endcase
		end
		if (base_tick) begin
			st_next.tick_cnt = 22'h000000;
			st_next.sub_cnt = sub_inc;
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 22'h000001;
		end
		case (mode)
			fcc_pkg::MODE_HOST_DUTY: begin
				st_next.duty = open_duty;
			end
			fcc_pkg::MODE_SPEED_LOOP: begin
				if (speed_tick && meas_en) begin
					st_next.duty = speed_duty;
				end
			end
			default: begin
				if (rate_tick) begin
					if (!gradual) begin
						st_next.duty = temp_target;
					end else if (ramp_diff > thresh) begin
						st_next.duty = step_toward(st_reg.duty, temp_target, step);
					end
				end
			end
		endcase
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			st_reg <= '{config_one: fcc_pkg::RST_CONFIG_ONE,
				speed_target: fcc_pkg::RST_SPEED_TARGET, default: '0};
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	assign duty_out = st_reg.duty;
	assign reg_rdata_out = st_reg.rdata;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	open_duty_a: assert property ((ce_in && mode == fcc_pkg::MODE_HOST_DUTY)
		|=> duty_out == $past(open_duty))
		else $error("open-loop duty not applied next cycle");
	low_cut_a: assert property ((ce_in && mode == fcc_pkg::MODE_HOST_DUTY && force_low
		&& st_reg.duty_setting < fcc_pkg::DUTY_SEVEN_PCT) |=> duty_out == 8'h00)
		else $error("low open-loop setting not forced to zero");
	speed_hold_a: assert property ((ce_in && mode == fcc_pkg::MODE_SPEED_LOOP
		&& !speed_tick && !reg_wr_in) |=> $stable(duty_out))
		else $error("speed loop moved between sample points");
	speed_floor_a: assert property ((ce_in && mode == fcc_pkg::MODE_SPEED_LOOP && speed_tick
		&& force_low) |=> duty_out >= fcc_pkg::DUTY_THIRTY_PCT)
		else $error("speed loop below thirty percent floor");
	speed_rise_a: assert property ((ce_in && mode == fcc_pkg::MODE_SPEED_LOOP && speed_tick
		&& meas_en && (meas_mode || st_reg.duty >= fcc_pkg::DUTY_THIRTY_PCT)
		&& meas_wide > tgt_wide + fcc_pkg::SPEED_BAND
		&& st_reg.duty < 8'hf0) |=> duty_out == $past(st_reg.duty) + $past(step))
		else $error("slow fan did not raise duty by one step");
	speed_band_a: assert property ((ce_in && mode == fcc_pkg::MODE_SPEED_LOOP
		&& (meas_mode || st_reg.duty >= fcc_pkg::DUTY_THIRTY_PCT)
		&& meas_wide <= tgt_wide + fcc_pkg::SPEED_BAND
		&& meas_wide + fcc_pkg::SPEED_BAND >= tgt_wide) |=> $stable(duty_out))
		else $error("speed loop adjusted inside tolerance band");
	temp_jump_a: assert property ((ce_in && mode[1] && rate_tick && !gradual)
		|=> duty_out == $past(temp_target))
		else $error("immediate temperature target not applied");
	temp_hold_a: assert property ((ce_in && mode[1] && !rate_tick && !reg_wr_in)
		|=> $stable(duty_out))
		else $error("temperature loop moved off its interval");
	ramp_step_a: assert property ((ce_in && mode[1] && rate_tick && gradual
		&& ramp_diff > thresh) |=> (duty_out != $past(st_reg.duty))
		&& ((duty_out > $past(st_reg.duty) ? duty_out - $past(st_reg.duty)
		: $past(st_reg.duty) - duty_out) <= $past(step)))
		else $error("ramp update outside one to four counts");
	passive_a: assert property ((mode[1] && remote_temp_in <= st_reg.passive_cool_temp
		&& local_temp_in <= st_reg.passive_cool_temp) |-> temp_target == 8'h00)
		else $error("passive cooling did not stop the fan");
	max_pick_a: assert property ((mode == fcc_pkg::MODE_MAX_LOOP)
		|-> raw_target >= remote_demand && raw_target >= local_demand)
		else $error("larger loop demand not chosen");

	host_mode_c: cover property (mode == fcc_pkg::MODE_HOST_DUTY && reg_wr_in
		&& reg_addr_in == fcc_pkg::ADDR_DUTY_SETTING);
	speed_step_c: cover property (mode == fcc_pkg::MODE_SPEED_LOOP && speed_tick && meas_en);
	ramp_step_c: cover property (mode[1] && rate_tick && gradual && ramp_diff > thresh);
	max_local_c: cover property (mode == fcc_pkg::MODE_MAX_LOOP && local_demand > remote_demand);

endmodule : fcc_core

/* File: include/fcc_pkg.sv */
// Constants, register map and shared types of the fan duty-cycle controller.
// Assumes one 50 MHz clock and same-clock temperature and speed-count sources.
//
// Overview of operation
// - Mode 00 drives host duty setting.
// - Host duty write takes effect immediately.
// - Open loop: setting below 7% outputs zero while speed measure is enabled and measure-mode clear.
// - Mode 01 regulates measured toward target speed count.
// - Regulator steps every second, or 250 ms fast.
// - Regulator steps by ramp step; band 0x000a.
// - Regulator floors duty at 30% unless measure-mode set.
// - Mode 10, default, uses remote loop only.
// - Mode 11 drives larger of both loop demands.
// - Target is min duty plus slope times excess.
// - At or below low temperature, minimum duty.
// - At or above derived high temperature, full duty.
// - At or below passive temperature, duty zero.
// - Gradual bit chooses immediate or stepped update.
// - Ramp interval picks 0.0625 to 8 seconds.
// - Each ramp update moves one to four counts.
// - Ramping stops within selected threshold.
// - Temperature modes: below 7% forced to zero while speed measure is enabled and measure-mode clear.
package fcc_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_CONFIG_ONE = 8'h00;
	localparam logic [7:0] ADDR_CONFIG_TWO = 8'h01;
	localparam logic [7:0] ADDR_MISC_CONFIG_FOUR = 8'h04;
	localparam logic [7:0] ADDR_DUTY_RAMP_CONTROL = 8'h23;
	localparam logic [7:0] ADDR_DUTY_SETTING = 8'h30;
	localparam logic [7:0] ADDR_REMOTE_LOOP = 8'h31;
	localparam logic [7:0] ADDR_LOCAL_LOOP = 8'h32;
	localparam logic [7:0] ADDR_MIN_TEMP_DUTY = 8'h33;
	localparam logic [7:0] ADDR_PASSIVE_COOL = 8'h34;
	localparam logic [7:0] ADDR_SPEED_TARGET_LO = 8'h35;
	localparam logic [7:0] ADDR_SPEED_TARGET_HI = 8'h36;

	// ==========================================================
	// Field positions
	localparam int MODE_HI_BIT = 6;
	localparam int MODE_LO_BIT = 5;
	localparam int SPEED_MEAS_EN_BIT = 2;
	localparam int SPEED_MEAS_MODE_BIT = 1;
	localparam int FAST_SAMPLE_BIT = 5;
	localparam int GRADUAL_BIT = 7;
	localparam int THRESH_HI_BIT = 6;
	localparam int THRESH_LO_BIT = 5;
	localparam int INTERVAL_HI_BIT = 4;
	localparam int INTERVAL_LO_BIT = 2;
	localparam int STEP_HI_BIT = 1;
	localparam int STEP_LO_BIT = 0;
	localparam int LOW_TEMP_HI_BIT = 7;
	localparam int LOW_TEMP_LO_BIT = 3;
	localparam int SLOPE_HI_BIT = 2;
	localparam int SLOPE_LO_BIT = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CONFIG_ONE = 8'hd4;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [15:0] RST_SPEED_TARGET = 16'hffff;

	// ==========================================================
	// Duty levels and limits
	localparam logic [7:0] DUTY_FULL = 8'hff;
	localparam logic [7:0] DUTY_SEVEN_PCT = 8'h12;
	localparam logic [7:0] DUTY_THIRTY_PCT = 8'h4d;
	localparam logic [16:0] SPEED_BAND = 17'h0000a;

	// ==========================================================
	// Timing
	localparam int CLOCK_MHZ = 50;
	localparam int BASE_TICK_US = 62500;
	localparam int BASE_TICK_CYCLES = BASE_TICK_US * CLOCK_MHZ;
	localparam logic [6:0] SLOW_SAMPLE_MASK = 7'h0f;
	localparam logic [6:0] FAST_SAMPLE_MASK = 7'h03;

	// Fan mode codes.
	typedef enum logic [1:0] {
		MODE_HOST_DUTY = 2'h0,
		MODE_SPEED_LOOP = 2'h1,
		MODE_REMOTE_LOOP = 2'h2,
		MODE_MAX_LOOP = 2'h3
	} fcc_mode_type;

	// All state of the controller.
	typedef struct packed {
		logic [7:0] config_one;
		logic [7:0] config_two;
		logic [7:0] misc_config_four;
		logic [7:0] duty_ramp_control;
		logic [7:0] duty_setting;
		logic [7:0] remote_loop;
		logic [7:0] local_loop;
		logic [7:0] min_temp_duty;
		logic [7:0] passive_cool_temp;
		logic [15:0] speed_target;
		logic [7:0] duty;
		logic [21:0] tick_cnt;
		logic [6:0] sub_cnt;
		logic [7:0] rdata;
	} fcc_state_type;

endpackage : fcc_pkg

/* File: bench/fcc_fan_model.sv */
// Behavioural cooling fan that turns the PWM duty into a speed count.
// Assumes the count is sampled on the controller clock; a bigger count means slower.
`timescale 1ns/1ps

module fcc_fan_model (
	input wire logic clock_in,
	input wire logic stall_in,
	input wire logic [7:0] duty_in,
	output logic [15:0] speed_count_out
);
	// ==========================================================
	// Speed count
	// A stalled rotor gives no tach edge, so the count runs to full scale.
	always_ff @(posedge clock_in) begin
		if (stall_in) begin
			speed_count_out <= 16'hffff;
		end else begin
			speed_count_out <= 16'h2000 - {4'h0, duty_in, 4'h0};
		end
	end
endmodule : fcc_fan_model

/* File: bench/tb.sv */
// Self-checking bench of the fan duty-cycle controller with a fan model.
// Assumes a shortened base tick of four cycles; inputs change at the falling edge.
`timescale 1ns/1ps

module tb;
	localparam int TICKS = 4;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic [7:0] remote_temp_in = 8'h00;
	logic [7:0] local_temp_in = 8'h00;
	logic [15:0] speed_count_in;
	logic [7:0] duty_out;
	logic stall = 1'b0;
	int bad_count = 0;
	int num_checks = 0;

	// ==========================================================
	// Clock, design and fan.
	always #10 clock_in = ~clock_in;

	fcc_core #(.TICK_CYCLES(TICKS)) fcc_core_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.ce_in(ce_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.remote_temp_in(remote_temp_in), .local_temp_in(local_temp_in),
		.speed_count_in(speed_count_in), .duty_out(duty_out));

	fcc_fan_model fcc_fan_model_i (.clock_in(clock_in), .stall_in(stall), .duty_in(duty_out),
		.speed_count_out(speed_count_in));

	// ==========================================================
	// Shared tasks.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clock_in);
		reg_wr_in = 1'b1;
		reg_addr_in = addr;
		reg_wdata_in = data;
		@(negedge clock_in);
		reg_wr_in = 1'b0;
	endtask : wr

	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge clock_in);
		reg_rd_in = 1'b1;
		reg_addr_in = addr;
		@(negedge clock_in);
		reg_rd_in = 1'b0;
		check("read data", {8'h00, reg_rdata_out}, {8'h00, exp});
	endtask : rd_check

	task automatic wait_change(input int limit, output int cyc);
		logic [7:0] prev;
		prev = duty_out;
		cyc = 0;
		while (duty_out === prev && cyc < limit) begin
			@(negedge clock_in);
			cyc++;
		end
	endtask : wait_change

	// Follows a run of equal duty steps, then sees that the duty comes to rest.
	task automatic run_steps(input logic [7:0] first, input logic [7:0] delta, input int n,
		input int gap);
		int cyc;
		logic [7:0] exp;
		exp = first;
		for (int i = 0; i < n; i++) begin
			wait_change(2 * gap + 8, cyc);
			check("duty step", {8'h00, duty_out}, {8'h00, exp});
			if (i > 0) check("step gap", cyc[15:0], gap[15:0]);
			exp = exp + delta;
		end
		wait_change(3 * gap, cyc);
		check("duty at rest", {8'h00, duty_out}, {8'h00, exp - delta});
	endtask : run_steps

	task automatic temp_check(input logic [7:0] rt, input logic [7:0] lt, input logic [7:0] exp);
		@(negedge clock_in);
		remote_temp_in = rt;
		local_temp_in = lt;
		repeat (8) @(negedge clock_in);
		check("loop duty", {8'h00, duty_out}, {8'h00, exp});
	endtask : temp_check

	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		check("reset duty", {8'h00, duty_out}, 16'h0000);
		rd_check(fcc_pkg::ADDR_CONFIG_ONE, 8'hd4);
		rd_check(fcc_pkg::ADDR_SPEED_TARGET_HI, 8'hff);
		rd_check(fcc_pkg::ADDR_MISC_CONFIG_FOUR, 8'h00);
		rd_check(8'h50, 8'h00);
		wr(fcc_pkg::ADDR_DUTY_RAMP_CONTROL, 8'h5a);
		rd_check(fcc_pkg::ADDR_DUTY_RAMP_CONTROL, 8'h5a);
	endtask : t_reset

	task automatic t_host();
		logic [7:0] tab [5][3] = '{'{8'h00, 8'h80, 8'h80}, '{8'h00, 8'h11, 8'h11},
			'{8'h04, 8'h11, 8'h00}, '{8'h04, 8'h12, 8'h12}, '{8'h06, 8'h11, 8'h11}};
		wr(fcc_pkg::ADDR_CONFIG_ONE, 8'h94);
		for (int i = 0; i < 5; i++) begin
			wr(fcc_pkg::ADDR_CONFIG_TWO, tab[i][0]);
			wr(fcc_pkg::ADDR_DUTY_SETTING, tab[i][1]);
			repeat (2) @(negedge clock_in);
			check("host duty", {8'h00, duty_out}, {8'h00, tab[i][2]});
		end
	endtask : t_host

	task automatic t_temp();
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h00);
		wr(fcc_pkg::ADDR_DUTY_RAMP_CONTROL, 8'h00);
		wr(fcc_pkg::ADDR_REMOTE_LOOP, 8'ha2);
		wr(fcc_pkg::ADDR_LOCAL_LOOP, 8'h2c);
		wr(fcc_pkg::ADDR_MIN_TEMP_DUTY, 8'h40);
		wr(fcc_pkg::ADDR_PASSIVE_COOL, 8'h0a);
		wr(fcc_pkg::ADDR_CONFIG_ONE, 8'hd4);
		temp_check(8'd10, 8'd90, 8'h00);
		temp_check(8'd11, 8'd0, 8'h40);
		temp_check(8'd20, 8'd0, 8'h40);
		temp_check(8'd21, 8'd0, 8'h42);
		temp_check(8'd114, 8'd0, 8'hfc);
		temp_check(8'd115, 8'd0, 8'hff);
		temp_check(8'd200, 8'd0, 8'hff);
		wr(fcc_pkg::ADDR_CONFIG_ONE, 8'hf4);
		temp_check(8'd25, 8'd25, 8'h90);
		temp_check(8'd25, 8'd6, 8'h4a);
		temp_check(8'd30, 8'd5, 8'h54);
		wr(fcc_pkg::ADDR_CONFIG_ONE, 8'hd4);
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h04);
		wr(fcc_pkg::ADDR_MIN_TEMP_DUTY, 8'h05);
		temp_check(8'd15, 8'd0, 8'h00);
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h06);
		temp_check(8'd15, 8'd0, 8'h05);
	endtask : t_temp

	task automatic t_ramp();
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h00);
		wr(fcc_pkg::ADDR_MIN_TEMP_DUTY, 8'h41);
		temp_check(8'd20, 8'd0, 8'h41);
		// Gradual on, threshold four counts, every second base tick, four-count steps.
		wr(fcc_pkg::ADDR_DUTY_RAMP_CONTROL, 8'hc7);
		@(negedge clock_in);
		remote_temp_in = 8'd30;
		run_steps(8'h45, 8'h04, 4, 2 * TICKS);
	endtask : t_ramp

	task automatic t_speed();
		int cyc;
		wr(fcc_pkg::ADDR_DUTY_RAMP_CONTROL, 8'h03);
		wr(fcc_pkg::ADDR_SPEED_TARGET_LO, 8'hf0);
		wr(fcc_pkg::ADDR_SPEED_TARGET_HI, 8'h19);
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h04);
		wr(fcc_pkg::ADDR_CONFIG_ONE, 8'hb4);
		// The interval write already jumped the duty to the remote target 0x55.
		run_steps(8'h59, 8'h04, 3, 16 * TICKS);
		wr(fcc_pkg::ADDR_MISC_CONFIG_FOUR, 8'h20);
		wr(fcc_pkg::ADDR_SPEED_TARGET_HI, 8'h1f);
		wr(fcc_pkg::ADDR_SPEED_TARGET_LO, 8'hff);
		run_steps(8'h5d, 8'hfc, 5, 4 * TICKS);
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h00);
		stall = 1'b1;
		wait_change(80, cyc);
		check("frozen duty", {8'h00, duty_out}, 16'h004d);
		wr(fcc_pkg::ADDR_CONFIG_TWO, 8'h04);
		wait_change(40, cyc);
		check("stall raise", {8'h00, duty_out}, 16'h0051);
	endtask : t_speed

	// ==========================================================
	// Verdict and run control.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (10) @(negedge clock_in);
		sys_rst_in = 1'b0;
		t_reset();
		t_host();
		t_temp();
		t_ramp();
		t_speed();
		print_verdict();
	end

	// The tests need about 900 cycles; this limit cuts a hang short.
	initial begin
		repeat (20000) @(posedge clock_in);
		bad_count++;
		print_verdict();
	end
endmodule : tb
